//--- shared/lced_pkg.sv
// Package for the legacy context entry decoder: field positions, codes,
// widths and reset values shared by the decoder and its request checker.
// Assumes a single clock domain and a 67-bit lower context entry image.
`default_nettype none
package lced_pkg;
   // Entry image width and field positions
   localparam int          ENTRY_W        = 67;
   localparam int          PRESENT_POS    = 0;
   localparam int          FSUP_POS       = 1;
   localparam int          TT_LSB         = 2;
   localparam int          TT_MSB         = 3;
   localparam int          RSV_LSB        = 4;
   localparam int          RSV_MSB        = 11;
   localparam int          PTR_LSB        = 12;
   localparam int          PTR_MSB        = 63;
   localparam int          GW_LSB         = 64;
   localparam int          GW_MSB         = 66;
   localparam int          PTR_W          = 52;
   localparam int          ADDR_W         = 64;
   // Platform host address width (bits of pointer from here up are reserved)
   localparam int          HOST_ADDR_W    = 46;
   // Guest width codes
   localparam logic [2:0]  GW_39          = 3'h1;
   localparam logic [2:0]  GW_48          = 3'h2;
   localparam logic [2:0]  GW_57          = 3'h3;
   localparam logic [6:0]  WIDTH_39       = 7'h27;
   localparam logic [6:0]  WIDTH_48       = 7'h30;
   localparam logic [6:0]  WIDTH_57       = 7'h39;
   localparam logic [2:0]  LEVELS_3       = 3'h3;
   localparam logic [2:0]  LEVELS_4       = 3'h4;
   localparam logic [2:0]  LEVELS_5       = 3'h5;
   // Translation type codes
   localparam logic [1:0]  TT_XLATE       = 2'h0;
   localparam logic [1:0]  TT_XLATE_DTLB  = 2'h1;
   localparam logic [1:0]  TT_PASS        = 2'h2;
   localparam logic [1:0]  TT_RSVD        = 2'h3;
   // Request kinds
   localparam logic [1:0]  REQ_UNTRANS    = 2'h0;
   localparam logic [1:0]  REQ_TRANSLATED = 2'h1;
   localparam logic [1:0]  REQ_XLATE_REQ  = 2'h2;
   // Verdict codes
   localparam logic [1:0]  VERD_BLOCK     = 2'h0;
   localparam logic [1:0]  VERD_WALK      = 2'h1;
   localparam logic [1:0]  VERD_PASS      = 2'h2;
   localparam logic [1:0]  VERD_ACCEPT    = 2'h3;
   // Reset values
   localparam logic [1:0]  VERD_RST       = 2'h0;
   localparam logic [6:0]  WIDTH_RST      = 7'h00;
   localparam logic [2:0]  LEVELS_RST     = 3'h0;
endpackage
`default_nettype wire

//--- rtl/lced_req_check.sv
// Request checker: combinational verdict for one request against a
// decoded entry. Assumes the entry fields are already split out.
`default_nettype none
module lced_req_check (
   input  wire logic                     present_in,        // Entry present
   input  wire logic                     entry_bad_in,      // Reserved code/bit seen
   input  wire logic [1:0]               tt_in,             // Translation type
   input  wire logic [6:0]               width_in,          // Decoded width
   input  wire logic                     has_pasid_in,      // Request carries PASID
   input  wire logic [1:0]               kind_in,           // Request kind
   input  wire logic [lced_pkg::ADDR_W-1:0] addr_in,        // Request address
   output logic      [1:0]               verdict_out,       // Verdict code
   output logic                          fault_out          // Translation fault
);
   import lced_pkg::*;

   logic over_range;                                        // Address beyond 2^width-1

   // =====================================================
   // Address range check
   always_comb begin
      over_range = 1'b0;
      if (width_in != WIDTH_RST && width_in < 7'(ADDR_W)) begin
         over_range = (addr_in >> width_in) != '0;
      end
   end

   // =====================================================
   // Verdict selection
   always_comb begin
      verdict_out = VERD_BLOCK;
      fault_out   = 1'b0;
      if (has_pasid_in) begin
         verdict_out = VERD_BLOCK;
      end else if (!present_in || entry_bad_in) begin
         fault_out   = 1'b1;
      end else begin
         case (tt_in)
            TT_XLATE: begin
               if (kind_in == REQ_UNTRANS && !over_range) begin
                  verdict_out = VERD_WALK;
               end else begin
                  fault_out = 1'b1;
               end
            end
            TT_XLATE_DTLB: begin
               if (kind_in != REQ_UNTRANS) begin
                  verdict_out = VERD_ACCEPT;
               end else if (!over_range) begin
                  verdict_out = VERD_WALK;
               end else begin
                  fault_out = 1'b1;
               end
            end
            TT_PASS: begin
               if (kind_in == REQ_UNTRANS && !over_range) begin
                  verdict_out = VERD_PASS;
               end else begin
                  fault_out = 1'b1;
               end
            end
            default: begin
               fault_out = 1'b1;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

//--- rtl/lced_decoder.sv
// Legacy context entry decoder: registers an entry image, decodes its
// width, type and pointer, and judges requests without delay of state.
// Assumes one clock domain; entry and requests come from logic on clk_in.
// Decoded fields stand two cycles after a load,
// verdicts one cycle after a request.
// Support inputs are read each cycle;
// change them only between loads.
// Requests carrying a PASID never reach the table.
//
// Operation
// - Width codes 1,2,3 give 39/48/57 bits.
// - Width sizes walk only for types 0,1.
// - Untranslated addresses above 2^width-1 block with fault.
// - Pointer is walk base for types 0,1.
// - Pointer bits above host width are reserved.
// - Pointer ignored for pass-through type.
// - Requests with PASID are always blocked.
// - Type 0 walks untranslated, blocks others.
// - Type 1 walks untranslated, accepts others; reserved without DTLB.
// - Type 2 passes untranslated; 3 reserved.
// - Suppress bit one hides fault reports.
// - Suppress bit evaluated even when absent.
// - Absent entry ignores all but suppress.
`default_nettype none
module lced_decoder (
   input  wire logic                          clk_in,              // 20 MHz clock
   input  wire logic                          resetn_in,           // Async reset, low
   input  wire logic                          entry_load_in,       // Load new entry image
   input  wire logic [lced_pkg::ENTRY_W-1:0]  entry_in,            // Lower 67 entry bits
   input  wire logic [2:0]                    supported_width_mask_in, // Widths offered
   input  wire logic                          device_tlb_supported_in,  // Device TLB support
   input  wire logic                          passthrough_supported_in, // Pass-through support
   input  wire logic                          req_valid_in,        // Request strobe
   input  wire logic                          req_has_pasid_in,    // Request has PASID
   input  wire logic [1:0]                    req_kind_in,         // Request kind
   input  wire logic [lced_pkg::ADDR_W-1:0]   req_addr_in,         // Request address
   output logic                               present_out,         // Entry present
   output logic      [6:0]                    adjusted_guest_width_out, // Walk width
   output logic      [2:0]                    walk_levels_out,     // Table levels
   output logic      [lced_pkg::PTR_W-1:0]    second_stage_table_pointer_out, // Walk base
   output logic                               entry_bad_out,       // Reserved content
   output logic                               verdict_valid_out,   // Verdict strobe
   output logic      [1:0]                    verdict_out,         // Verdict code
   output logic                               fault_out,           // Translation fault
   output logic                               fault_report_out     // Fault to record
);
   import lced_pkg::*;

   // =====================================================
   // Stored entry and decoded fields
   // Only the image is state;
   // the rest are slices and decodes
   logic [ENTRY_W-1:0] entry_ff;                  // Held entry image
   logic               present;                   // Present bit
   logic               fault_suppress_bit;        // Suppress bit
   logic [1:0]         translation_type_field;    // Type field
   logic [2:0]         guest_width_field;         // Width field
   logic [PTR_W-1:0]   ptr_raw;                   // Raw pointer field
   logic               width_ok;                  // Width code defined and supported
   logic               type_ok;                   // Type code usable here
   logic               rsv_ok;                    // Reserved bits all zero
   logic               ptr_ok;                    // Pointer high bits zero
   logic               is_walk;                   // Type selects translation
   logic [6:0]         nxt_width;                 // Decoded width
   logic [2:0]         nxt_levels;                // Decoded levels
   logic [1:0]         chk_verdict;               // Checker verdict
   logic               chk_fault;                 // Checker fault
   logic               bad;                       // Reserved content seen

   // Fields read the stored copy, so a load
   // cannot tear a verdict in flight
   assign present                = entry_ff[PRESENT_POS];
   assign fault_suppress_bit     = entry_ff[FSUP_POS];
   assign translation_type_field = entry_ff[TT_MSB:TT_LSB];
   assign guest_width_field      = entry_ff[GW_MSB:GW_LSB];
   assign ptr_raw                = entry_ff[PTR_MSB:PTR_LSB];
   // Types 00 and 01 walk the tables
   assign is_walk = (translation_type_field == TT_XLATE) ||
                    (translation_type_field == TT_XLATE_DTLB);

   // =====================================================
   // Entry capture
   // Reset clears the image: the entry reads
   // as absent and requests without a PASID fault until a load.
   // The image changes only on a load.
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         entry_ff <= '0;
      end else if (entry_load_in) begin
         entry_ff <= entry_in;
      end
   end

   // =====================================================
   // Width decode
   // An unoffered width counts as reserved
   always_comb begin
      nxt_width  = WIDTH_RST;
      nxt_levels = LEVELS_RST;
      width_ok   = 1'b0;
      // Defaults cover codes 0 and 4 to 7
      case (guest_width_field)
         GW_39: begin
            nxt_width  = WIDTH_39;
            // Three table levels
            nxt_levels = LEVELS_3;
            width_ok   = supported_width_mask_in[0];
         end
         GW_48: begin
            nxt_width  = WIDTH_48;
            // Four table levels
            nxt_levels = LEVELS_4;
            width_ok   = supported_width_mask_in[1];
         end
         GW_57: begin
            nxt_width  = WIDTH_57;
            // Five table levels
            nxt_levels = LEVELS_5;
            width_ok   = supported_width_mask_in[2];
         end
         default: begin
            width_ok = 1'b0;                       // Reserved codes
         end
      endcase
   end

   // =====================================================
   // Reserved content checks
   // Optional types need their support input
   always_comb begin
      // Type usability, present or not
      case (translation_type_field)
         TT_XLATE:      type_ok = 1'b1;
         TT_XLATE_DTLB: type_ok = device_tlb_supported_in;
         TT_PASS:       type_ok = passthrough_supported_in;
         default:       type_ok = 1'b0;
      endcase
   end

   // Reserved bits between pointer and type must be zero
   assign rsv_ok = entry_ff[RSV_MSB:RSV_LSB] == '0;
   // Pointer high bits checked only when the pointer is used
   assign ptr_ok = !is_walk ||
                   ptr_raw[PTR_W-1:HOST_ADDR_W-PTR_LSB] == '0;
   // Width checked whatever the type; pass-through still needs a defined, offered one
   assign bad = !(width_ok && type_ok && rsv_ok && ptr_ok);

   // =====================================================
   // Request checker
   // Combinational; answered through the
   // verdict registers one cycle later
   lced_req_check u_check (
      .present_in   (present),
      .entry_bad_in (bad),
      .tt_in        (translation_type_field),
      .width_in     (nxt_width),
      .has_pasid_in (req_has_pasid_in),
      .kind_in      (req_kind_in),
      .addr_in      (req_addr_in),
      .verdict_out  (chk_verdict),
      .fault_out    (chk_fault)
   );

   // =====================================================
   // Decoded entry outputs
   // Walk fields zero unless a present entry walks, so no
   // walk starts from a stale pointer
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         present_out                    <= 1'b0;
         adjusted_guest_width_out       <= WIDTH_RST;
         walk_levels_out                <= LEVELS_RST;
         second_stage_table_pointer_out <= '0;
         entry_bad_out                  <= 1'b0;
      end else begin
         // Flags follow the image every cycle
         present_out   <= present;
         entry_bad_out <= present && bad;
         // Walk fields only for types 00 and 01
         if (present && is_walk) begin
            adjusted_guest_width_out       <= nxt_width;
            walk_levels_out                <= nxt_levels;
            second_stage_table_pointer_out <= ptr_raw;
         end else begin
            // Absent, pass-through or reserved type
            adjusted_guest_width_out       <= WIDTH_RST;
            walk_levels_out                <= LEVELS_RST;
            second_stage_table_pointer_out <= '0;
         end
      end
   end

   // =====================================================
   // Request verdict registers
   // Zero between requests: each verdict
   // stands for exactly one cycle
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         verdict_valid_out <= 1'b0;
         verdict_out       <= VERD_RST;
         fault_out         <= 1'b0;
         fault_report_out  <= 1'b0;
      end else begin
         // Valid trails the request by one edge
         verdict_valid_out <= req_valid_in;
         // Judged only on a request
         if (req_valid_in) begin
            verdict_out      <= chk_verdict;
            fault_out        <= chk_fault;
            // Suppress bit read regardless of present
            fault_report_out <= chk_fault && !fault_suppress_bit;
         end else begin
            // Idle: nothing to report
            verdict_out      <= VERD_RST;
            fault_out        <= 1'b0;
            fault_report_out <= 1'b0;
         end
      end
   end

   // =====================================================
   // Assertions
   // Each looks one edge ahead, matching the
   // registered answers; all rest in reset
   AST_PASID_BLOCK: assert property (@(posedge clk_in) disable iff (!resetn_in)
      req_valid_in && req_has_pasid_in |=> verdict_valid_out && verdict_out == VERD_BLOCK)
      else $error("PASID request not blocked");

   AST_SUPPRESS: assert property (@(posedge clk_in) disable iff (!resetn_in)
      req_valid_in && fault_suppress_bit && !entry_load_in |=> !fault_report_out)
      else $error("Fault reported while suppressed");

   AST_REPORT: assert property (@(posedge clk_in) disable iff (!resetn_in)
      req_valid_in && !req_has_pasid_in && !present && !fault_suppress_bit
      && !entry_load_in |=> fault_report_out && fault_out)
      else $error("Absent entry fault not reported");

   AST_ABSENT_NO_WALK: assert property (@(posedge clk_in) disable iff (!resetn_in)
      !present |=> walk_levels_out == LEVELS_RST && second_stage_table_pointer_out == '0)
      else $error("Absent entry decoded");

   AST_WIDTH_48: assert property (@(posedge clk_in) disable iff (!resetn_in)
      present && is_walk && guest_width_field == GW_48 |=>
      adjusted_guest_width_out == WIDTH_48 && walk_levels_out == LEVELS_4)
      else $error("48-bit width decode wrong");

   AST_PASS_NO_PTR: assert property (@(posedge clk_in) disable iff (!resetn_in)
      translation_type_field == TT_PASS |=> second_stage_table_pointer_out == '0)
      else $error("Pointer used in pass-through");

   AST_TT0_BLOCK: assert property (@(posedge clk_in) disable iff (!resetn_in)
      req_valid_in && !req_has_pasid_in && translation_type_field == TT_XLATE
      && req_kind_in != REQ_UNTRANS |=> verdict_out == VERD_BLOCK && fault_out)
      else $error("Type 0 passed translated request");

   AST_OVER_RANGE: assert property (@(posedge clk_in) disable iff (!resetn_in)
      req_valid_in && !req_has_pasid_in && present && nxt_width == WIDTH_39
      && req_addr_in[ADDR_W-1:39] != '0 && req_kind_in == REQ_UNTRANS
      |=> verdict_out == VERD_BLOCK && fault_out)
      else $error("Out-of-range address not blocked");

   AST_TT3_BLOCK: assert property (@(posedge clk_in) disable iff (!resetn_in)
      req_valid_in && !req_has_pasid_in && translation_type_field == TT_RSVD
      |=> verdict_out == VERD_BLOCK)
      else $error("Reserved type not blocked");

   // The pointer follows the image
   AST_PTR_BASE: assert property (@(posedge clk_in) disable iff (!resetn_in)
      present && is_walk |=> second_stage_table_pointer_out == $past(ptr_raw))
      else $error("Walk base pointer not taken");

   // High pointer bits flag only for a walk
   AST_PTR_RSV: assert property (@(posedge clk_in) disable iff (!resetn_in)
      present && is_walk && ptr_raw[PTR_W-1:HOST_ADDR_W-PTR_LSB] != '0 |=> entry_bad_out)
      else $error("Reserved pointer bits not flagged");

   // A bad entry faults whatever its type
   AST_BAD_FAULT: assert property (@(posedge clk_in) disable iff (!resetn_in)
      req_valid_in && !req_has_pasid_in && bad |=> verdict_out == VERD_BLOCK && fault_out)
      else $error("Reserved entry content not faulted");

   // Only a clean type 01 entry accepts
   AST_ACCEPT: assert property (@(posedge clk_in) disable iff (!resetn_in)
      req_valid_in && !req_has_pasid_in && present && !bad && req_kind_in != REQ_UNTRANS
      && translation_type_field == TT_XLATE_DTLB |=> verdict_out == VERD_ACCEPT && !fault_out)
      else $error("Type 1 translated request not accepted");

   // =====================================================
   // Coverage of the main verdict kinds
   COV_WALK: cover property (@(posedge clk_in) verdict_valid_out && verdict_out == VERD_WALK);
   COV_PASS: cover property (@(posedge clk_in) verdict_valid_out && verdict_out == VERD_PASS);
   COV_ACCEPT: cover property (@(posedge clk_in) verdict_valid_out && verdict_out == VERD_ACCEPT);
   // A fault with no report shows suppression
   COV_SUPPRESSED: cover property (@(posedge clk_in) fault_out && !fault_report_out);
   COV_REPORTED: cover property (@(posedge clk_in) fault_report_out);
endmodule
`default_nettype wire

//--- verif/lced_endpoint_model.sv
// Endpoint model: issues DMA and translation requests into the decoder.
// Assumes the bench calls send just after a rising edge of clk_in.
`default_nettype none
module lced_endpoint_model (
   input  wire logic                        clk_in,            // Decoder clock
   output logic                             req_valid_out,     // Request strobe
   output logic                             req_has_pasid_out, // Request carries PASID
   output logic      [1:0]                  req_kind_out,      // Request kind
   output logic      [lced_pkg::ADDR_W-1:0] req_addr_out       // Request address
);
   timeunit 1ns;
   timeprecision 100ps;
   import lced_pkg::*;
   // ==========================================
   // Idle lines at time zero
   initial begin
      req_valid_out     = 1'b0;
      req_has_pasid_out = 1'b0;
      req_kind_out      = REQ_UNTRANS;
      req_addr_out      = '0;
   end
   // Hold one request across one sampling edge; back to back calls allowed
   task automatic send(input logic p, input logic [1:0] k, input logic [ADDR_W-1:0] a);
      req_valid_out     = 1'b1;
      req_has_pasid_out = p;
      req_kind_out      = k;
      req_addr_out      = a;
      @(posedge clk_in);
      #5;
   endtask
   // Released lines show the inverse so stale values are never reused
   task automatic release_lines();
      req_valid_out     = 1'b0;
      req_has_pasid_out = ~req_has_pasid_out;
      req_kind_out      = ~req_kind_out;
      req_addr_out      = ~req_addr_out;
   endtask
endmodule
`default_nettype wire

//--- verif/testbench.sv
// Self-checking bench for the legacy context entry decoder.
// Assumes one 20 MHz clock; all inputs change 5 ns after a rising edge.
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
   $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import lced_pkg::*;
   // ==========================================
   // Signals
   logic                clk_in, resetn_in, entry_load_in, dtlb, pt;
   logic [ENTRY_W-1:0]  entry_in, held;
   logic [2:0]          mask;
   logic                req_valid, req_pasid, present_out, entry_bad_out;
   logic [1:0]          req_kind, verdict_out;
   logic [ADDR_W-1:0]   req_addr;
   logic [6:0]          adjusted_guest_width_out;
   logic [2:0]          walk_levels_out;
   logic [PTR_W-1:0]    ptr_out;
   logic                verdict_valid_out, fault_out, fault_report_out;
   int                  mismatches, compares, cycles, seed;
   lced_decoder lced_decoder_i (.clk_in(clk_in), .resetn_in(resetn_in),
      .entry_load_in(entry_load_in), .entry_in(entry_in), .supported_width_mask_in(mask),
      .device_tlb_supported_in(dtlb), .passthrough_supported_in(pt),
      .req_valid_in(req_valid), .req_has_pasid_in(req_pasid), .req_kind_in(req_kind),
      .req_addr_in(req_addr), .present_out(present_out),
      .adjusted_guest_width_out(adjusted_guest_width_out), .walk_levels_out(walk_levels_out),
      .second_stage_table_pointer_out(ptr_out), .entry_bad_out(entry_bad_out),
      .verdict_valid_out(verdict_valid_out), .verdict_out(verdict_out),
      .fault_out(fault_out), .fault_report_out(fault_report_out));
   lced_endpoint_model lced_endpoint_model_i (.clk_in(clk_in), .req_valid_out(req_valid),
      .req_has_pasid_out(req_pasid), .req_kind_out(req_kind), .req_addr_out(req_addr));
   // ==========================================
   // Clock and hang guard
   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 20000) begin // Whole run needs about 2800 cycles
         mismatches++;
         tally_and_finish();
      end
   end
   // ==========================================
   // Expectation functions
   // Width and levels of a width code, zero for reserved codes
   function automatic logic [9:0] wl(input logic [2:0] g);
      case (g)
         GW_39:   return {WIDTH_39, LEVELS_3};
         GW_48:   return {WIDTH_48, LEVELS_4};
         GW_57:   return {WIDTH_57, LEVELS_5};
         default: return 10'h000;
      endcase
   endfunction
   // Width in bits of a width code, zero for reserved codes
   function automatic logic [6:0] wd(input logic [2:0] g);
      logic [9:0] d;
      d = wl(g);
      return d[9:3];
   endfunction
   // Present entry holding a reserved or unsupported code or bit
   function automatic logic is_bad(input logic [ENTRY_W-1:0] e);
      logic [1:0] t;
      t = e[3:2];
      return e[0] && (wl(e[66:64]) == 10'h000 || !mask[e[65:64] - 2'h1] || t == TT_RSVD
         || (t == TT_XLATE_DTLB && !dtlb) || (t == TT_PASS && !pt) || e[11:4] != 8'h00
         || (t < 2'h2 && e[63:HOST_ADDR_W] != '0));
   endfunction
   // Verdict, fault and report for one request against entry e
   function automatic logic [3:0] exp_req(input logic [ENTRY_W-1:0] e, input logic p,
                                         input logic [1:0] k, input logic [63:0] a);
      logic [1:0] v;
      logic       f;
      v = VERD_BLOCK;
      f = 1'b0;
      if (p) f = 1'b0;
      else if (!e[0] || is_bad(e)) f = 1'b1;
      else if (e[3:2] == TT_XLATE_DTLB && k != REQ_UNTRANS) v = VERD_ACCEPT;
      else if (k != REQ_UNTRANS || (a >> wd(e[66:64])) != 64'h0) f = 1'b1;
      else v = (e[3:2] == TT_PASS) ? VERD_PASS : VERD_WALK;
      return {v, f, f & ~e[1]};
   endfunction
   // ==========================================
   // Drivers
   // Load an entry, scramble the bus, then check the decoded fields
   task automatic load(input logic [ENTRY_W-1:0] e);
      logic [9:0] d;
      logic       go;
      entry_in = e;
      entry_load_in = 1'b1;
      held = e;
      @(posedge clk_in);
      #5;
      entry_load_in = 1'b0;
      entry_in = ~e;
      @(posedge clk_in);
      #5;
      d = wl(e[66:64]);
      go = e[0] && e[3:2] < 2'h2;
      `CHK(present_out, e[0])
      `CHK(entry_bad_out, is_bad(e))
      `CHK(verdict_valid_out, 1'b0)
      if (!is_bad(e)) begin
         `CHK(adjusted_guest_width_out, go ? d[9:3] : 7'h00)
         `CHK(walk_levels_out, go ? d[2:0] : 3'h0)
         `CHK(ptr_out, go ? e[63:12] : 52'h0)
      end
   endtask
   // One request, checked in the cycle its verdict stands
   task automatic req(input logic p, input logic [1:0] k, input logic [63:0] a);
      logic [3:0] x;
      x = exp_req(held, p, k, a);
      lced_endpoint_model_i.send(p, k, a);
      `CHK(verdict_valid_out, 1'b1)
      `CHK(verdict_out, x[3:2])
      `CHK(fault_out, x[1])
      `CHK(fault_report_out, x[0])
   endtask
   // Requests of every kind at both sides of the width limit
   task automatic burst(input logic [63:0] lim);
      for (int k = 0; k < 4; k++) begin
         req(1'b0, k[1:0], lim - 64'h1);
         req(1'b0, k[1:0], lim);
      end
      req(1'b1, REQ_UNTRANS, 64'h0);
      lced_endpoint_model_i.release_lines();
      @(posedge clk_in);
      #5;
   endtask
   task automatic tally_and_finish();
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // ==========================================
   // Main sequence
   initial begin
      logic [63:0]        p64;
      logic [ENTRY_W-1:0] e;
      seed = 32'h0cef;
      mismatches = 0;
      compares = 0;
      cycles = 0;
      resetn_in = 1'b0;
      entry_load_in = 1'b0;
      entry_in = '0;
      mask = 3'h7;
      dtlb = 1'b1;
      pt = 1'b1;
      held = '0;
      for (int r = 0; r < 2; r++) begin // Start-up reset, then once more later
         resetn_in = 1'b0;
         repeat (3) @(posedge clk_in);
         #5;
         resetn_in = 1'b1;
         held = '0;
         @(posedge clk_in);
         #5;
         `CHK(present_out, 1'b0)
         `CHK(adjusted_guest_width_out, WIDTH_RST)
         burst(64'h1);
         // Sweep every type and width code with and without the optional support
         for (int c = 0; c < 2; c++) for (int t = 0; t < 4; t++) for (int g = 0; g < 8; g++) begin
            mask = c ? 3'h7 : 3'h1;
            dtlb = c[0];
            pt = c[0];
            p64 = {$random(seed), $random(seed)} & ((64'h1 << HOST_ADDR_W) - 64'h1);
            e = {g[2:0], p64[63:12], 8'h00, t[1:0], t[0] ^ g[0], ~(g[2] & t[0])};
            load(e);
            burst(64'h1 << wd(g[2:0]));
         end
      end
      // Random entries, mostly clean, some with reserved content
      for (int n = 0; n < 150; n++) begin
         {mask, dtlb, pt} = 5'($random(seed));
         e = ENTRY_W'({$random(seed), $random(seed), $random(seed)});
         if ($random(seed) & 3) begin
            e[11:4] = 8'h00;
            e[63:HOST_ADDR_W] = '0;
            e[66:64] = 3'($unsigned($random(seed)) % 3 + 1);
            e[0] = 1'b1;
         end
         load(e);
         p64 = 64'h1 << wd(e[66:64]);
         for (int q = 0; q < 6; q++) begin
            req(1'($random(seed)), 2'($random(seed)),
                ($random(seed) & 1) ? p64 : {$random(seed), $random(seed)} % p64);
         end
         lced_endpoint_model_i.release_lines();
      end
      tally_and_finish();
   end
endmodule
`default_nettype wire
